// ### shared/alert_fmt_pkg.sv
// constants for the alert-mask and output-voltage format register block
package alert_fmt_pkg;

  // ---------------------------------------------------------------
  // command codes and selectors
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_ALERT_MASK  = 8'h1b;
  localparam logic [7:0] CMD_VOUT_FORMAT = 8'h20;
  localparam logic [7:0] SEL_COMM_MEM    = 8'h7e;
  localparam logic [7:0] SEL_OTHER       = 8'h7f;
  localparam logic [7:0] SEL_VENDOR      = 8'h80;

  // ---------------------------------------------------------------
  // communication/memory mask layout
  // ---------------------------------------------------------------
  localparam int BAD_COMMAND_MASK_BIT     = 7;
  localparam int BAD_PAYLOAD_MASK_BIT     = 6;
  localparam int PACKET_CHECK_MASK_BIT    = 5;
  localparam int MEMORY_FAULT_MASK_BIT    = 4;
  localparam int LINK_FAULT_MASK_BIT      = 1;
  localparam logic [7:0] COMM_WR_BITS     = 8'hf2;

  // ---------------------------------------------------------------
  // other-group mask layout
  // ---------------------------------------------------------------
  localparam int EARLIEST_ALERTER_MASK_BIT = 0;
  localparam logic [7:0] OTHER_FIXED       = 8'h01;

  // ---------------------------------------------------------------
  // vendor-group mask layout
  // ---------------------------------------------------------------
  localparam int POWERUP_RESET_MASK_BIT   = 7;
  localparam int SELF_CHECK_MASK_BIT      = 6;
  localparam int RESET_PIN_MASK_BIT       = 3;
  localparam int BACKCHANNEL_MASK_BIT     = 2;
  localparam int SYNC_FAULT_MASK_BIT      = 1;
  localparam logic [7:0] VENDOR_WR_BITS   = 8'hce;

  // ---------------------------------------------------------------
  // output-voltage format layout
  // ---------------------------------------------------------------
  localparam int RELATIVE_BIT             = 7;
  localparam int MODE_MSB                 = 6;
  localparam int MODE_LSB                 = 5;
  localparam int PARAM_MSB                = 4;
  localparam int PARAM_LSB                = 0;
  localparam logic [7:0] FORMAT_WR_BITS   = 8'h9f;
  localparam logic [1:0] MODE_LINEAR      = 2'h0;
  localparam logic signed [4:0] EXP_MAX   = -5'sd4;
  localparam logic signed [4:0] EXP_MIN   = -5'sd12;

  // ---------------------------------------------------------------
  // values held until the non-volatile image is loaded
  // ---------------------------------------------------------------
  localparam logic [7:0] COMM_RESET       = 8'hf2;
  localparam logic [7:0] VENDOR_RESET     = 8'hce;
  localparam logic [7:0] FORMAT_RESET     = 8'h14;

endpackage

// ### src/alert_fmt_regs.sv
// alert-mask registers, output-voltage format register and alert gating
`timescale 1ns/1ps

// Summary of operation
// - set mask bit blocks its alert source
// - comm mask writable bits 7,6,5,4,1
// - selectors 7Eh, 7Fh and 80h under command 1Bh
// - word write sets, process call reads mask
// - other mask reads 01h, read-only
// - vendor mask writable bits 7,6,3,2,1
// - unmasked self check may alert at power-up
// - unmasked sync may pulse alert on enable
// - format register at 20h, byte access
// - format writable only while conversion disabled
// - format is 2-bit mode, 5-bit parameter
// - mode picks format, parameter qualifies it
// - masks load from nvm, act at once
// - bit 7 relative, mode fixed linear 00b
// - linear exponent range -4 to -12
module alert_fmt_regs
  import alert_fmt_pkg::*;
(
  input  wire logic       sys_clk,          // system clock, 125 MHz
  input  wire logic       resetn,           // async reset, active low
  input  wire logic       nvm_load,         // pulse: copy nvm image into registers
  input  wire logic [7:0] nvm_comm_mask,    // stored comm/memory mask
  input  wire logic [7:0] nvm_vendor_mask,  // stored vendor mask
  input  wire logic [7:0] nvm_format,       // stored output-voltage format
  input  wire logic       wr_stb,           // pulse: host write transaction
  input  wire logic       rd_stb,           // pulse: host read transaction
  input  wire logic [7:0] cmd_code,         // command code
  input  wire logic [7:0] sel_code,         // selector byte for mask command
  input  wire logic [7:0] wr_data,          // data byte to write
  output logic            rd_valid,         // pulse: rd_data is valid
  output logic      [7:0] rd_data,          // read data byte
  output logic            cmd_refused,      // pulse: access not accepted
  input  wire logic       conversion_en,    // power conversion enabled
  input  wire logic [7:0] comm_status,      // comm/memory status conditions
  input  wire logic [7:0] other_status,     // other-group status conditions
  input  wire logic [7:0] vendor_status,    // vendor status conditions
  output logic      [7:0] comm_mask,        // current comm/memory mask
  output logic      [7:0] vendor_mask,      // current vendor mask
  output logic      [7:0] format_byte,      // current output-voltage format
  output logic            fmt_relative,     // relative data format selected
  output logic      [4:0] fmt_exponent,     // linear exponent
  output logic            fmt_exp_ok,       // exponent inside supported range
  output logic            alert_active,     // alert condition present
  input  wire logic       alert_in,         // alert pin level seen
  output logic            alert_out,        // alert pin drive value
  output logic            alert_oe,         // alert pin drive enable
  output logic            alert_line_low    // alert wire is pulled low
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0] comm_q,   comm_d;
  logic [7:0] vendor_q, vendor_d;
  logic [7:0] format_q, format_d;
  logic [7:0] rdata_q,  rdata_d;
  logic       rvalid_q, rvalid_d;
  logic       refuse_q, refuse_d;
  logic       alert_q,  alert_d;
  logic       line_q,   line_d;

  logic       hit_comm, hit_other, hit_vendor, hit_format;

  assign hit_comm   = (cmd_code == CMD_ALERT_MASK) && (sel_code == SEL_COMM_MEM);
  assign hit_other  = (cmd_code == CMD_ALERT_MASK) && (sel_code == SEL_OTHER);
  assign hit_vendor = (cmd_code == CMD_ALERT_MASK) && (sel_code == SEL_VENDOR);
  assign hit_format = (cmd_code == CMD_VOUT_FORMAT);

  // ---------------------------------------------------------------
  // write and read handling
  // ---------------------------------------------------------------
  always_comb begin
    comm_d   = comm_q;
    vendor_d = vendor_q;
    format_d = format_q;
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    refuse_d = 1'b0;
    if (nvm_load) begin
      // stored image; read-only fields keep their fixed values
      comm_d   = nvm_comm_mask & COMM_WR_BITS;
      vendor_d = nvm_vendor_mask & VENDOR_WR_BITS;
      format_d = nvm_format & FORMAT_WR_BITS;
    end else if (wr_stb) begin
      if (hit_comm) begin
        comm_d = wr_data & COMM_WR_BITS;
      end else if (hit_vendor) begin
        vendor_d = wr_data & VENDOR_WR_BITS;
      end else if (hit_other) begin
        refuse_d = 1'b0;
      end else if (hit_format) begin
        if (conversion_en) begin
          refuse_d = 1'b1;
        end else begin
          format_d = wr_data & FORMAT_WR_BITS;
        end
      end else begin
        refuse_d = 1'b1;
      end
    end else if (rd_stb) begin
      rvalid_d = 1'b1;
      if (hit_comm) begin
        rdata_d = comm_q;
      end else if (hit_other) begin
        rdata_d = OTHER_FIXED;
      end else if (hit_vendor) begin
        rdata_d = vendor_q;
      end else if (hit_format) begin
        rdata_d = format_q;
      end else begin
        rdata_d  = 8'h00;
        refuse_d = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // alert gating
  // ---------------------------------------------------------------
  always_comb begin
    // a set mask bit blocks its condition; unsupported comm and vendor bits never alert, other-group bits 7:1 always pass
    alert_d = (|(comm_status & COMM_WR_BITS & ~comm_q))
            | (|(other_status & ~OTHER_FIXED))
            | (|(vendor_status & VENDOR_WR_BITS & ~vendor_q));
    // alert_line_low follows the inverted alert pin level, one cycle later
    line_d  = ~alert_in;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      comm_q   <= COMM_RESET;
      vendor_q <= VENDOR_RESET;
      format_q <= FORMAT_RESET;
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
      refuse_q <= 1'b0;
      alert_q  <= 1'b0;
      line_q   <= 1'b0;
    end else begin
      comm_q   <= comm_d;
      vendor_q <= vendor_d;
      format_q <= format_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      refuse_q <= refuse_d;
      alert_q  <= alert_d;
      line_q   <= line_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rd_valid       = rvalid_q;
  assign rd_data        = rdata_q;
  assign cmd_refused    = refuse_q;
  assign comm_mask      = comm_q;
  assign vendor_mask    = vendor_q;
  assign format_byte    = format_q;
  assign fmt_relative   = format_q[RELATIVE_BIT];
  assign fmt_exponent   = format_q[PARAM_MSB:PARAM_LSB];
  assign fmt_exp_ok     = (format_q[MODE_MSB:MODE_LSB] == MODE_LINEAR)
                        && ($signed(format_q[PARAM_MSB:PARAM_LSB]) <= EXP_MAX)
                        && ($signed(format_q[PARAM_MSB:PARAM_LSB]) >= EXP_MIN);
  assign alert_active   = alert_q;
  assign alert_out      = 1'b0;
  assign alert_oe       = alert_q;
  assign alert_line_low = line_q;

endmodule

// ### sim/alert_fmt_regs_checker.sv
// checker: port assertions for the alert-mask and format registers
`timescale 1ns/1ps
module alert_fmt_regs_checker
  import alert_fmt_pkg::*;
(
  input wire logic       sys_clk, resetn,                       // clock, reset
  input wire logic       nvm_load, wr_stb, rd_stb, conversion_en, // requests
  input wire logic [7:0] cmd_code, sel_code, wr_data, rd_data,  // bytes
  input wire logic       rd_valid, cmd_refused, alert_active, alert_oe, alert_out, // answers
  input wire logic [7:0] comm_status, other_status, vendor_status, // conditions
  input wire logic [7:0] comm_mask, vendor_mask, format_byte     // registers
);
  wire logic wr_go = wr_stb & ~nvm_load;
  wire logic rd_go = rd_stb & ~wr_stb & ~nvm_load;
  wire logic cond = |(comm_status & 8'hf2 & ~comm_mask) | |(other_status & 8'hfe)
                  | |(vendor_status & 8'hce & ~vendor_mask);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_read_answered: assert property (rd_go |=> rd_valid)
    else $error("read not answered");
  a_other_fixed: assert property (rd_go && cmd_code == 8'h1b && sel_code == 8'h7f |=> rd_data == 8'h01)
    else $error("other mask read wrong");
  a_comm_writes: assert property (wr_go && cmd_code == 8'h1b && sel_code == 8'h7e
    |=> comm_mask == ($past(wr_data) & 8'hf2)) else $error("comm mask write wrong");
  a_vendor_writes: assert property (wr_go && cmd_code == 8'h1b && sel_code == 8'h80
    |=> vendor_mask == ($past(wr_data) & 8'hce)) else $error("vendor mask write wrong");
  a_format_locked: assert property (wr_go && conversion_en && cmd_code == 8'h20
    |=> cmd_refused && $stable(format_byte)) else $error("format not locked");
  a_mode_linear: assert property (format_byte[6:5] == 2'h0)
    else $error("mode field not linear");
  a_alert_gating: assert property ($past(resetn) |-> alert_active == $past(cond))
    else $error("alert gating wrong");
  a_pin_drive: assert property (alert_oe == alert_active && alert_out == 1'b0)
    else $error("alert pin drive wrong");
endmodule

bind alert_fmt_regs alert_fmt_regs_checker alert_fmt_regs_checker_inst (.sys_clk, .resetn, .nvm_load,
  .wr_stb, .rd_stb, .conversion_en, .cmd_code, .sel_code, .wr_data, .rd_data, .rd_valid, .cmd_refused,
  .alert_active, .alert_oe, .alert_out, .comm_status, .other_status, .vendor_status, .comm_mask,
  .vendor_mask, .format_byte);

// ### sim/pmbus_host_model.sv
// host model: issues single-cycle transactions on the command port
`timescale 1ns/1ps
module pmbus_host_model (
  input  wire logic       sys_clk,               // clock
  input  wire logic       rd_valid, cmd_refused, // answers
  input  wire logic [7:0] rd_data,               // read byte
  output logic            wr_stb, rd_stb,        // strobes
  output logic      [7:0] cmd_code, sel_code, wr_data // bytes
);
  initial begin
    {wr_stb, rd_stb} = 2'h0;
    {cmd_code, sel_code, wr_data} = 24'h5a5a5a;
  end
  // word write or process-call read: selector and data in one cycle
  task automatic xfer(input logic w, input logic [7:0] c, s, d, output logic [7:0] rdat,
                      output logic vld, refd);
    @(negedge sys_clk);
    {wr_stb, rd_stb, cmd_code, sel_code, wr_data} = {w, ~w, c, s, d};
    @(negedge sys_clk);
    {rdat, vld, refd} = {rd_data, rd_valid, cmd_refused};
    // released bytes show the inverse, never the last value
    {wr_stb, rd_stb, cmd_code, sel_code, wr_data} = {2'h0, ~c, ~s, ~d};
  endtask
endmodule

// ### sim/tb_top.sv
// testbench: register access and alert gating scenarios
`timescale 1ns/1ps
module tb_top;
  logic       sys_clk = 1'b0, resetn = 1'b0, nvm_load = 1'b0, conversion_en = 1'b0;
  logic [7:0] nvm_comm_mask = 8'h0d, nvm_vendor_mask = 8'h31, nvm_format = 8'h7c;
  logic [7:0] comm_status = 8'h00, other_status = 8'h00, vendor_status = 8'h00;
  logic       wr_stb, rd_stb, rd_valid, cmd_refused, alert_active, alert_out, alert_oe, alert_line_low;
  logic       fmt_relative, fmt_exp_ok, vld, refd;
  logic [4:0] fmt_exponent;
  logic [7:0] cmd_code, sel_code, wr_data, rd_data, comm_mask, vendor_mask, format_byte, rdat;
  int         num_errors = 0;
  int         samples_checked = 0;
  wire logic  alert_in = alert_oe ? alert_out : 1'b1;
  always #4 sys_clk = ~sys_clk;
  alert_fmt_regs alert_fmt_regs_inst (.sys_clk, .resetn, .nvm_load, .nvm_comm_mask, .nvm_vendor_mask,
    .nvm_format, .wr_stb, .rd_stb, .cmd_code, .sel_code, .wr_data, .rd_valid, .rd_data, .cmd_refused,
    .conversion_en, .comm_status, .other_status, .vendor_status, .comm_mask, .vendor_mask, .format_byte,
    .fmt_relative, .fmt_exponent, .fmt_exp_ok, .alert_active, .alert_in, .alert_out, .alert_oe,
    .alert_line_low);
  pmbus_host_model pmbus_host_model_inst (.sys_clk, .rd_valid, .cmd_refused, .rd_data, .wr_stb,
    .rd_stb, .cmd_code, .sel_code, .wr_data);
  task automatic chk(input string nm, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] c, s, d);
    pmbus_host_model_inst.xfer(w, c, s, d, rdat, vld, refd);
  endtask
  task automatic t_load;
    chk("comm reset", 8'hf2, comm_mask);
    nvm_load = 1'b1;
    @(negedge sys_clk);
    nvm_load = 1'b0;
    chk("comm load", 8'h00, comm_mask);
    chk("vendor load", 8'h00, vendor_mask);
    chk("fmt load", 8'h1c, format_byte);
    $display("test load done");
  endtask
  task automatic t_masks;
    xf(1, 8'h1b, 8'h7e, 8'hff);
    chk("comm mask", 8'hf2, comm_mask);
    xf(1, 8'h1b, 8'h80, 8'hff);
    chk("vendor mask", 8'hce, vendor_mask);
    xf(0, 8'h1b, 8'h80, 8'h00);
    chk("vendor read", 8'hce, rdat);
    xf(1, 8'h1b, 8'h7f, 8'h00);
    xf(0, 8'h1b, 8'h7f, 8'h00);
    chk("other read", 8'h01, rdat);
    chk("read valid", 8'h01, {7'h0, vld});
    xf(0, 8'h1b, 8'h7c, 8'h00);
    chk("bad selector", 8'h01, {7'h0, refd});
    $display("test masks done");
  endtask
  task automatic t_format;
    xf(1, 8'h20, 8'h00, 8'hff);
    chk("fmt write", 8'h9f, format_byte);
    chk("fmt flags", 8'hbe, {fmt_relative, fmt_exp_ok, fmt_exponent, 1'b0});
    xf(1, 8'h20, 8'h00, 8'h14);
    chk("fmt flags", 8'h68, {fmt_relative, fmt_exp_ok, fmt_exponent, 1'b0});
    conversion_en = 1'b1;
    xf(1, 8'h20, 8'h00, 8'h1c);
    chk("fmt locked", 8'h01, {7'h0, refd});
    xf(0, 8'h20, 8'h00, 8'h00);
    chk("fmt read", 8'h14, rdat);
    conversion_en = 1'b0;
    $display("test format done");
  endtask
  task automatic t_alert;
    xf(1, 8'h1b, 8'h7e, 8'h00);
    comm_status = 8'hff;
    repeat (2) @(negedge sys_clk);
    chk("alert pin", 8'h03, {6'h0, alert_active, alert_line_low});
    xf(1, 8'h1b, 8'h7e, 8'hf2);
    @(negedge sys_clk);
    {comm_status, other_status, vendor_status} = {8'h0d, 8'h01, 8'h42};
    repeat (2) @(negedge sys_clk);
    chk("alert masked", 8'h00, {7'h0, alert_active});
    xf(1, 8'h1b, 8'h80, 8'h80);
    @(negedge sys_clk);
    chk("alert unmasked", 8'h01, {7'h0, alert_active});
    vendor_status = 8'h00;
    repeat (3) @(negedge sys_clk);
    chk("alert idle", 8'h00, {6'h0, alert_active, alert_line_low});
    $display("test alert done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge sys_clk);
    resetn = 1'b1;
    t_load();
    t_masks();
    t_format();
    t_alert();
    complete_run();
  end
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
endmodule
